/* File: rtl/rpc_pkg.sv */
// Package of constants for the per-port receive configuration registers.
// Overview of operation
// - Each port keeps its own register copy; port-select bits pick which ports host writes reach; reads use the lowest.
// - Host address matching alias bits 7:1 is forwarded using remote target address.
// - Alias value zero disables the entry; nothing is routed through it.
// - Bit 0 set makes the device acknowledge host writes itself; clear uses remote acknowledge.
// - Option bit 7 set discards packets until frame start with frame count one.
// - Option bit 6 set (reset one) discards packets until any frame start.
// - Frame-start waits and checksum forwarding have no effect in raw input formats.
// - Option bit 5 forwards (1, reset) or drops (0) checksum-errored packets.
// - Option bit 4 forwards (1, reset) or drops (0) header-errored packets.
// - In CSI-2 format option bit 3 forwards or drops length-errored packets.
// - In raw format bit 3 set drops a truncated first line; clear forwards it.
// - Format 00 CSI-2, 01 raw12 low, 10 raw12 high, 11 raw10.
// - Format field resets from strap sampled after each reset release; software may overwrite.
// - Pin1 source select in bits 7:4, pin0 source select in bits 3:0.
// - Select code with top bit clear sends local pin indexed by low three bits.
// - Code 1000 (reset) sends constant 0; code 1001 sends constant 1.
// - Code 1010 sends the frame sync pulse; codes 1011 to 1111 are reserved.
package rpc_pkg;
  localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
  localparam logic [7:0] ALIAS7_ADDR = 8'h6C;
  localparam logic [7:0] OPTIONS_ADDR = 8'h6D;
  localparam logic [7:0] BC_SELECT_ADDR = 8'h6E;
  localparam logic [7:0] ALIAS7_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_RESET = 8'h70;
  localparam logic [7:0] BC_SELECT_RESET = 8'h88;
  localparam logic [7:0] OPTIONS_WRITE_MASK = 8'hFB;
  localparam int OPT_WAIT_FC1 = 7;
  localparam int OPT_WAIT_FS = 6;
  localparam int OPT_FWD_CKSUM = 5;
  localparam int OPT_FWD_ECC = 4;
  localparam int OPT_FWD_LEN = 3;
  localparam int ALIAS_AUTO_ACK = 0;
  localparam logic [3:0] SEL_CONST0 = 4'h8;
  localparam logic [3:0] SEL_CONST1 = 4'h9;
  localparam logic [3:0] SEL_FSYNC = 4'hA;
  localparam logic [1:0] FMT_CSI2 = 2'h0;
  localparam logic [1:0] FMT_RAW12_LF = 2'h1;
  localparam logic [1:0] FMT_RAW12_HF = 2'h2;
  localparam logic [1:0] FMT_RAW10 = 2'h3;
endpackage

/* File: rtl/rpc_bc_mux.sv */
// Back-channel source multiplexer for one transmitted pin.
`timescale 1ns/100ps
module rpc_bc_mux
  import rpc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Source selection.
  input wire logic [3:0] sel_in,
  input wire logic [7:0] gpio_in,
  input wire logic fsync_in,
  // Chosen level.
  output logic bc_out
);
  logic bc_ff;
  logic nxt_bc;

  always_comb begin
    if (!sel_in[3]) begin
      nxt_bc = gpio_in[sel_in[2:0]];
    end else if (sel_in == SEL_CONST1) begin
      nxt_bc = 1'b1;
    end else if (sel_in == SEL_FSYNC) begin
      nxt_bc = fsync_in;
    end else begin
      // Constant 0 and the reserved codes send a low level.
      nxt_bc = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bc_ff <= 1'b0;
    end else begin
      bc_ff <= nxt_bc;
    end
  end

  assign bc_out = bc_ff;
endmodule

/* File: rtl/rpc_regs.sv */
// Per-port receive configuration registers with alias match and packet gating.
`timescale 1ns/100ps
module rpc_regs
  import rpc_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Strap for the input format, sampled after reset release.
  input wire logic [1:0] link_input_format_strap_in,
  // Register access from the I2C target engine.
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Host address decode, checked against every port's alias entry.
  input wire logic host_addr_valid_in,
  input wire logic [6:0] host_addr_in,
  input wire logic host_is_write_in,
  input wire logic [NUM_PORTS-1:0] remote_ack_in,
  input wire logic [6:0] remote_target_id_in [NUM_PORTS],
  output logic [NUM_PORTS-1:0] alias_hit_out,
  output logic [6:0] remote_addr_out,
  output logic host_ack_out,
  // CSI-2 packet stream, one per port.
  input wire logic [NUM_PORTS-1:0] pkt_valid_in,
  input wire logic [NUM_PORTS-1:0] pkt_is_fs_in,
  input wire logic [15:0] pkt_frame_count_in [NUM_PORTS],
  input wire logic [NUM_PORTS-1:0] pkt_cksum_err_in,
  input wire logic [NUM_PORTS-1:0] pkt_ecc_err_in,
  input wire logic [NUM_PORTS-1:0] pkt_len_err_in,
  output logic [NUM_PORTS-1:0] pkt_forward_out,
  // Raw pixel first-line handling, one per port.
  input wire logic [NUM_PORTS-1:0] raw_first_line_short_in,
  output logic [NUM_PORTS-1:0] raw_drop_line_out,
  // Back channel sources.
  input wire logic [7:0] gpio_in,
  input wire logic camera_sync_pulse_in,
  output logic [NUM_PORTS-1:0] backchannel_pin0_out,
  output logic [NUM_PORTS-1:0] backchannel_pin1_out,
  // Configuration seen by each port.
  output logic [1:0] link_input_format_out [NUM_PORTS]
);
  localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

  logic [7:0] port_select_ff;
  logic [7:0] alias_ff [NUM_PORTS];
  logic [7:0] options_ff [NUM_PORTS];
  logic [7:0] bc_select_ff [NUM_PORTS];
  logic strap_done_ff;
  logic [NUM_PORTS-1:0] fs_seen_ff;
  logic [NUM_PORTS-1:0] pkt_forward_ff;
  logic [NUM_PORTS-1:0] raw_drop_ff;
  logic [NUM_PORTS-1:0] alias_hit_ff;
  logic [6:0] remote_addr_ff;
  logic host_ack_ff;
  logic [7:0] reg_rdata_ff;

  function automatic logic is_raw(input logic [1:0] fmt);
    return fmt != FMT_CSI2;
  endfunction

  // Port-select bit n enables writes to port n; reads come from the lowest selected port.
  function automatic logic [PW-1:0] rd_port(input logic [7:0] sel);
    logic [PW-1:0] idx;
    idx = '0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (sel[p]) begin
        idx = PW'(p);
      end
    end
    return idx;
  endfunction

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port_select_ff <= 8'h01;
    end else if (reg_wr_in && reg_addr_in == PORT_SELECT_ADDR) begin
      port_select_ff <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        alias_ff[p] <= ALIAS7_RESET;
        options_ff[p] <= OPTIONS_RESET;
        bc_select_ff[p] <= BC_SELECT_RESET;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!strap_done_ff) begin
          options_ff[p][1:0] <= link_input_format_strap_in;
        end else if (reg_wr_in && port_select_ff[p]) begin
          unique case (reg_addr_in)
            ALIAS7_ADDR: alias_ff[p] <= reg_wdata_in;
            OPTIONS_ADDR: options_ff[p] <= reg_wdata_in & OPTIONS_WRITE_MASK;
            BC_SELECT_ADDR: bc_select_ff[p] <= reg_wdata_in;
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        PORT_SELECT_ADDR: reg_rdata_ff <= port_select_ff;
        ALIAS7_ADDR: reg_rdata_ff <= alias_ff[rd_port(port_select_ff)];
        OPTIONS_ADDR: reg_rdata_ff <= options_ff[rd_port(port_select_ff)];
        BC_SELECT_ADDR: reg_rdata_ff <= bc_select_ff[rd_port(port_select_ff)];
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  // Alias decode; the lowest matching port wins the remap address.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alias_hit_ff <= '0;
      remote_addr_ff <= 7'h00;
      host_ack_ff <= 1'b0;
    end else begin
      alias_hit_ff <= '0;
      remote_addr_ff <= 7'h00;
      host_ack_ff <= 1'b0;
      if (host_addr_valid_in) begin
        for (int p = NUM_PORTS - 1; p >= 0; p--) begin
          if (alias_ff[p][7:1] != 7'h00 && alias_ff[p][7:1] == host_addr_in) begin
            alias_hit_ff[p] <= 1'b1;
            remote_addr_ff <= remote_target_id_in[p];
            host_ack_ff <= (alias_ff[p][ALIAS_AUTO_ACK] && host_is_write_in)
                           || remote_ack_in[p];
          end
        end
      end
    end
  end

  // Packet gating per port.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fs_seen_ff <= '0;
      pkt_forward_ff <= '0;
      raw_drop_ff <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        logic [7:0] o;
        logic raw;
        logic fs_ok;
        logic gate_open;
        logic err_ok;
        o = options_ff[p];
        raw = is_raw(o[1:0]);
        fs_ok = pkt_is_fs_in[p] &&
                (!o[OPT_WAIT_FC1] || pkt_frame_count_in[p] == 16'h0001);
        gate_open = raw || fs_seen_ff[p] ||
                    (!o[OPT_WAIT_FC1] && !o[OPT_WAIT_FS]) || fs_ok;
        err_ok = (raw || o[OPT_FWD_CKSUM] || !pkt_cksum_err_in[p]) &&
                 (o[OPT_FWD_ECC] || !pkt_ecc_err_in[p]) &&
                 (raw || o[OPT_FWD_LEN] || !pkt_len_err_in[p]);
        if (pkt_valid_in[p] && fs_ok) begin
          fs_seen_ff[p] <= 1'b1;
        end
        pkt_forward_ff[p] <= pkt_valid_in[p] && gate_open && err_ok;
        raw_drop_ff[p] <= raw && o[OPT_FWD_LEN] && raw_first_line_short_in[p];
      end
    end
  end

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    rpc_bc_mux u_pin0 (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .sel_in(bc_select_ff[g][3:0]),
      .gpio_in(gpio_in),
      .fsync_in(camera_sync_pulse_in),
      .bc_out(backchannel_pin0_out[g])
    );
    rpc_bc_mux u_pin1 (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .sel_in(bc_select_ff[g][7:4]),
      .gpio_in(gpio_in),
      .fsync_in(camera_sync_pulse_in),
      .bc_out(backchannel_pin1_out[g])
    );
    assign link_input_format_out[g] = options_ff[g][1:0];
  end

  assign reg_rdata_out = reg_rdata_ff;
  assign alias_hit_out = alias_hit_ff;
  assign remote_addr_out = remote_addr_ff;
  assign host_ack_out = host_ack_ff;
  assign pkt_forward_out = pkt_forward_ff;
  assign raw_drop_line_out = raw_drop_ff;
endmodule

/* File: verif/rpc_regs_sva.sv */
// Port-level assertions for the receive configuration registers.
`timescale 1ns/100ps
module rpc_regs_sva
  import rpc_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // Clock, reset and register access.
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_rdata_out,
  // Alias decode.
  input wire logic host_addr_valid_in,
  input wire logic [6:0] host_addr_in,
  input wire logic host_is_write_in,
  input wire logic [NUM_PORTS-1:0] remote_ack_in,
  input wire logic [6:0] remote_target_id_in [NUM_PORTS],
  input wire logic [NUM_PORTS-1:0] alias_hit_out,
  input wire logic [6:0] remote_addr_out,
  input wire logic host_ack_out,
  // Packet and line handling.
  input wire logic [NUM_PORTS-1:0] pkt_valid_in,
  input wire logic [NUM_PORTS-1:0] pkt_ecc_err_in,
  input wire logic [NUM_PORTS-1:0] pkt_forward_out,
  input wire logic [NUM_PORTS-1:0] raw_first_line_short_in,
  input wire logic [NUM_PORTS-1:0] raw_drop_line_out,
  input wire logic [1:0] link_input_format_out [NUM_PORTS]
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  hit_cause_a: assert property (!host_addr_valid_in |=> alias_hit_out == '0)
    else $error("alias hit without host address");
  remap_addr_a: assert property (alias_hit_out[0] |->
    remote_addr_out == $past(remote_target_id_in[0])) else $error("wrong remap address");
  zero_alias_a: assert property (host_addr_valid_in && host_addr_in == 7'h00
    |=> alias_hit_out == '0) else $error("zero alias matched");
  ack_source_a: assert property (host_ack_out |-> $past(host_addr_valid_in) &&
    ($past(host_is_write_in) || $past(remote_ack_in) != '0)) else $error("bad acknowledge");
  fwd_valid_a: assert property (!pkt_valid_in[0] |=> !pkt_forward_out[0])
    else $error("forward without packet");
  raw_pass_a: assert property (pkt_valid_in[0] && !pkt_ecc_err_in[0] &&
    link_input_format_out[0] != FMT_CSI2 |=> pkt_forward_out[0]) else $error("raw dropped");
  raw_drop_a: assert property (raw_drop_line_out[0] |-> $past(raw_first_line_short_in[0])
    && $past(link_input_format_out[0]) != FMT_CSI2) else $error("bad line drop");
  rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved");
  rsvd_zero_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OPTIONS_ADDR
    |-> !reg_rdata_out[2]) else $error("reserved bit set");
  cover property (alias_hit_out[0] && host_ack_out);
  cover property (pkt_forward_out[0]);
  cover property (raw_drop_line_out[0]);
endmodule
bind rpc_regs rpc_regs_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.ref_clk_in, .resetn_in,
  .reg_rd_in, .reg_addr_in, .reg_rdata_out, .host_addr_valid_in, .host_addr_in,
  .host_is_write_in, .remote_ack_in, .remote_target_id_in, .alias_hit_out, .remote_addr_out,
  .host_ack_out, .pkt_valid_in, .pkt_ecc_err_in, .pkt_forward_out, .raw_first_line_short_in,
  .raw_drop_line_out, .link_input_format_out);

/* File: verif/rpc_remote_model.sv */
// Behavioural remote serializer giving each port its target address and acknowledge.
`timescale 1ns/100ps
module rpc_remote_model #(
  parameter int NUM_PORTS = 4
) (
  // Bench control.
  input wire logic ack_en_in,
  // Link answers.
  output logic [NUM_PORTS-1:0] remote_ack_out,
  output logic [6:0] remote_target_id_out [NUM_PORTS]
);
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      remote_target_id_out[p] = 7'h50 + 7'(p);
    end
  end
  assign remote_ack_out = {NUM_PORTS{ack_en_in}};
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the receive configuration registers.
`timescale 1ns/100ps
module tb;
  import rpc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, hv = 1'b0, hw = 1'b0, ack_en = 1'b0;
  logic sync = 1'b1, hack;
  logic [1:0] strap = 2'h1, pv = 2'h0, pfs = 2'h0, pck = 2'h0, pec = 2'h0, pln = 2'h0;
  logic [1:0] psh = 2'h0, hit, rack, fwd, drp, bc0, bc1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, gpio = 8'hA5;
  logic [6:0] haddr = 7'h00, raddr;
  logic [15:0] fc [2] = '{16'h0000, 16'h0000};
  logic [6:0] rid [2];
  logic [1:0] fmt [2];
  int error_cnt = 0, compares = 0;
  logic [31:0] rows [10] = '{32'h006C0000, 32'h006D0071, 32'h006E0088, 32'h016DFFFB,
    32'h016E5A5A, 32'h016F5500, 32'h016C4141, 32'h014C0202, 32'h006C0000, 32'h014C0101};
  rpc_remote_model #(.NUM_PORTS(2)) u_remote (.ack_en_in(ack_en), .remote_ack_out(rack),
    .remote_target_id_out(rid));
  rpc_regs #(.NUM_PORTS(2)) dut (.ref_clk_in(clk), .resetn_in(rstn),
    .link_input_format_strap_in(strap), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .host_addr_valid_in(hv),
    .host_addr_in(haddr), .host_is_write_in(hw), .remote_ack_in(rack),
    .remote_target_id_in(rid), .alias_hit_out(hit), .remote_addr_out(raddr),
    .host_ack_out(hack), .pkt_valid_in(pv), .pkt_is_fs_in(pfs), .pkt_frame_count_in(fc),
    .pkt_cksum_err_in(pck), .pkt_ecc_err_in(pec), .pkt_len_err_in(pln),
    .pkt_forward_out(fwd), .raw_first_line_short_in(psh), .raw_drop_line_out(drp),
    .gpio_in(gpio), .camera_sync_pulse_in(sync), .backchannel_pin0_out(bc0),
    .backchannel_pin1_out(bc1), .link_input_format_out(fmt));
  initial forever #25 clk = ~clk;
  task conclude;
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // A read when w is low; either way the access ends one edge after it is taken.
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task host(input logic [6:0] a, input logic w, input logic k, input logic [9:0] exp);
    @(posedge clk);
    hv <= 1'b1;
    haddr <= a;
    hw <= w;
    ack_en <= k;
    @(posedge clk);
    hv <= 1'b0;
    #1;
    chk({hit, hack, (hit != 2'h0) ? raddr : 7'h00}, exp);
  endtask
  // Flags are valid, frame start, checksum, header, length and short first line.
  task pkt(input int p, input logic [5:0] s, input logic [15:0] c, input logic [1:0] exp);
    @(posedge clk);
    {pv[p], pfs[p], pck[p], pec[p], pln[p], psh[p]} <= s;
    fc[p] <= c;
    @(posedge clk);
    {pv[p], pfs[p], pck[p], pec[p], pln[p], psh[p]} <= 6'h00;
    #1;
    chk({fwd[p], drp[p]}, exp);
  endtask
  initial begin
    #1000000;
    error_cnt++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      if (rows[i][24]) acc(1'b1, rows[i][23:16], rows[i][15:8]);
      acc(1'b0, rows[i][23:16], 8'h00);
      chk(rdata, rows[i][7:0]);
    end
    for (int f = 0; f < 4; f++) begin
      acc(1'b1, OPTIONS_ADDR, 8'(f));
      chk({fmt[1], fmt[0]}, {2'h1, 2'(f)});
    end
    for (int c = 0; c < 12; c++) begin
      acc(1'b1, BC_SELECT_ADDR, {4'h5, 4'(c)});
      repeat (2) @(posedge clk);
      #1;
      chk({bc1, bc0}, {2'b01, 1'b0, c < 8 ? gpio[c] : (c == 9 || c == 10)});
    end
    // The sync source must follow its input, not read as a constant high.
    acc(1'b1, BC_SELECT_ADDR, {4'h5, SEL_FSYNC});
    @(posedge clk);
    sync <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({bc1[0], bc0[0]}, 2'b10);
    host(7'h20, 1'b1, 1'b0, {2'b01, 1'b1, 7'h50});
    host(7'h20, 1'b0, 1'b0, {2'b01, 1'b0, 7'h50});
    host(7'h21, 1'b1, 1'b0, {2'b00, 1'b0, 7'h00});
    acc(1'b1, ALIAS7_ADDR, 8'h40);
    host(7'h20, 1'b1, 1'b1, {2'b01, 1'b1, 7'h50});
    host(7'h20, 1'b1, 1'b0, {2'b01, 1'b0, 7'h50});
    acc(1'b1, ALIAS7_ADDR, 8'h00);
    host(7'h00, 1'b1, 1'b0, {2'b00, 1'b0, 7'h00});
    host(7'h20, 1'b1, 1'b0, {2'b00, 1'b0, 7'h00});
    pkt(0, 6'b101000, 16'h0000, 2'b10);
    pkt(0, 6'b100100, 16'h0000, 2'b00);
    acc(1'b1, OPTIONS_ADDR, 8'h40);
    pkt(0, 6'b100000, 16'h0000, 2'b00);
    pkt(0, 6'b110000, 16'h0005, 2'b10);
    pkt(0, 6'b100000, 16'h0000, 2'b10);
    for (int e = 0; e < 3; e++) begin
      acc(1'b1, OPTIONS_ADDR, 8'h40);
      pkt(0, 6'b100000 | 6'(2 << e), 16'h0000, 2'b00);
      acc(1'b1, OPTIONS_ADDR, 8'h38);
      pkt(0, 6'b100000 | 6'(2 << e), 16'h0000, 2'b10);
    end
    acc(1'b1, PORT_SELECT_ADDR, 8'h02);
    acc(1'b1, OPTIONS_ADDR, 8'h80);
    pkt(1, 6'b110000, 16'h0002, 2'b00);
    pkt(1, 6'b100000, 16'h0000, 2'b00);
    pkt(1, 6'b110000, 16'h0001, 2'b10);
    pkt(1, 6'b100000, 16'h0000, 2'b10);
    acc(1'b1, PORT_SELECT_ADDR, 8'h01);
    acc(1'b1, OPTIONS_ADDR, 8'h09);
    pkt(0, 6'b000001, 16'h0000, 2'b01);
    acc(1'b1, OPTIONS_ADDR, 8'h01);
    pkt(0, 6'b000001, 16'h0000, 2'b00);
    acc(1'b1, OPTIONS_ADDR, 8'h08);
    pkt(0, 6'b000001, 16'h0000, 2'b00);
    @(posedge clk);
    rstn <= 1'b0;
    strap <= 2'h2;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    acc(1'b0, OPTIONS_ADDR, 8'h00);
    chk(rdata, 8'h72);
    acc(1'b0, BC_SELECT_ADDR, 8'h00);
    chk(rdata, 8'h88);
    conclude;
  end
endmodule
